// ---- core/valve_status_pkg.sv ----
// package: register map, field layouts, timing and types for valve status
package valve_status_pkg;

  // register byte addresses on the avalon slave (word aligned)
  localparam logic [5:0] ctrl_off       = 6'h00;
  localparam logic [5:0] valve_off      = 6'h04;
  localparam logic [5:0] param_addr_off = 6'h08;
  localparam logic [5:0] param_data_off = 6'h0c;
  localparam logic [5:0] param_attr_off = 6'h10;
  localparam logic [5:0] param_val_off  = 6'h14;
  localparam logic [5:0] steps_in_off   = 6'h18;
  localparam logic [5:0] steps_out_off  = 6'h1c;
  localparam logic [5:0] irq_stat_off   = 6'h20;
  localparam logic [5:0] irq_mask_off   = 6'h24;
  localparam logic [5:0] status_off     = 6'h28;
  localparam logic [5:0] reboot_off     = 6'h2c;

  // ctrl register fields
  localparam int ctrl_mode_lsb   = 0;
  localparam int ctrl_src_bit    = 4;
  localparam int ctrl_micro_lsb  = 8;
  // valve register fields, one byte per valve
  localparam int valve_power_bit = 0;
  localparam int valve_ready_bit = 1;
  localparam int valve_comm_bit  = 2;
  localparam int valve_closed_bit = 3;
  localparam int valve_alarm_bit = 4;
  // param_attr fields
  localparam int attr_signed_bit = 0;
  localparam int attr_reboot_bit = 1;
  localparam int attr_acc_lsb    = 2;
  localparam int attr_width_lsb  = 8;
  // param_data write: source flag sits just above the 16-bit value
  localparam int data_src_bit    = 16;
  // interrupt status bits
  localparam int irq_applied_bit = 0;
  localparam int irq_pending_bit = 1;
  localparam int irq_denied_bit  = 2;
  localparam int irq_alarm_bit   = 3;
  localparam int irq_bits        = 4;

  // reset values
  localparam logic [31:0] ctrl_rst     = 32'h0000_0800;
  localparam logic [31:0] valve_rst    = 32'h0000_0000;
  localparam logic [3:0]  irq_mask_rst = 4'h0;

  localparam int num_valves = 2;

  // timing: one tick per millisecond at 100 MHz
  localparam int clk_mhz        = 100;
  localparam int tick_us        = 1000;
  localparam int tick_cycles    = tick_us * clk_mhz;
  localparam int slow_half_ms   = 500;
  localparam int mid_half_ms    = 250;
  localparam int fast_half_ms   = 125;
  localparam int period_ms      = 2 * slow_half_ms;

  // signed-value conversion threshold and offset
  localparam logic [16:0] signed_limit  = 17'h0_7fff;
  localparam logic [16:0] signed_offset = 17'h1_0000;

  typedef enum logic [1:0] {
    mode_full,
    mode_half,
    mode_micro,
    mode_bad
  } drive_mode_t;

  typedef enum logic [1:0] {
    acc_ro,
    acc_wo,
    acc_rw,
    acc_none
  } access_t;

  // attributes that describe a parameter slot
  typedef struct packed {
    logic [7:0] width_bits;
    access_t    access;
    logic       reboot_req;
    logic       signed_value_flag;
  } param_attr_t;

  // led drive bundle
  typedef struct packed {
    logic       alarm;
    logic [1:0] valve;
  } led_t;

  // avalon request bundle
  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } avs_req_t;

endpackage

// ---- core/valve_status.sv ----
// valve driver led patterns and parameter decode behind an avalon slave
//
// Functional notes
// - slow, mid, fast blink, equal halves
// - alarm led blinks slow on any alarm
// - alarm led dark without any alarm
// - green led dark without supply
// - green led blinks when link established
// - green led blinks slow when closed
// - signed raw above 32767 minus 65536
// - unflagged parameters pass unsigned, unconverted
// - reboot-required values apply after restart
// - other values apply at once
// - access type read-only, write-only, read/write enforced
// - parameter keyed by modbus address, width; here both are only stored and read back, one slot for all
// - mode code 0 full, 1 half, 2 micro
// - step values converted to selected mode
// - later bus writes replace service writes
`timescale 1ns/1ps

module valve_status
  import valve_status_pkg::*;
(
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic [5:0]                   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  output logic                              avs_response_err,
  output valve_status_pkg::led_t            led,
  output logic                              irq
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // byte-lane merge of a write into a word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // raw 16-bit value to 32-bit two's complement per signed flag
  function automatic logic [31:0] decode_val(input logic [15:0] raw,
                                             input logic        sflag);
    logic [16:0] wide;
    wide = {1'b0, raw};
    if (sflag && (wide > signed_limit)) begin
      wide = wide - signed_offset;
      return {{15{wide[16]}}, wide};
    end
    return {16'h0000, raw};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, answer on the second edge

  avs_req_t    req;
  logic        busy_r;
  logic        hit;
  logic [31:0] rdata_nxt;
  logic        rerr_nxt;

  // a request seen while busy is the one being answered, never a new one
  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata};
  assign hit = (req.read || req.write) && busy_r;

  // waitrequest drops for exactly one cycle per access
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r          <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      busy_r          <= (req.read || req.write) && !busy_r;
      avs_waitrequest <= !((req.read || req.write) && !busy_r);
    end
  end

  wire wr_any = hit && req.write;
  wire rd_any = hit && req.read;

  ////////////////////////////////////////////////////////////////////////////
  // control, valve status and parameter staging registers

  logic [31:0] ctrl_r;
  logic [31:0] valve_r;
  logic [15:0] param_addr_r;
  logic [15:0] param_data_r;
  param_attr_t attr_r;
  logic [15:0] steps_in_r;
  logic        src_service_r;
  logic        pend_valid_r;

  // software-written configuration
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r       <= ctrl_rst;
      valve_r      <= valve_rst;
      param_addr_r <= 16'h0000;
      attr_r       <= '0;
      steps_in_r   <= 16'h0000;
    end else if (wr_any) begin
      unique case (req.address)
        ctrl_off:       ctrl_r  <= merge(ctrl_r, req.writedata, avs_byteenable);
        valve_off:      valve_r <= merge(valve_r, req.writedata, avs_byteenable);
        param_addr_off: param_addr_r <= req.writedata[15:0];
        param_attr_off: begin
          // field by field: the word layout has gaps that the struct lacks
          attr_r.width_bits <= req.writedata[attr_width_lsb +: 8];
          attr_r.access <= access_t'(req.writedata[attr_acc_lsb +: 2]);
          attr_r.reboot_req <= req.writedata[attr_reboot_bit];
          attr_r.signed_value_flag <= req.writedata[attr_signed_bit];
        end
        steps_in_off:   steps_in_r <= req.writedata[15:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parameter write path: access check, immediate or deferred apply

  logic [31:0] applied_r;
  logic [15:0] pend_data_r;
  logic        write_ok;
  logic        read_ok;
  logic        data_wr;
  logic        reboot_wr;

  assign data_wr   = wr_any && (req.address == param_data_off);
  assign reboot_wr = wr_any && (req.address == reboot_off);
  // source bit: 1 = service port, 0 = expansion bus controller
  wire src_service = req.writedata[data_src_bit];
  assign write_ok  = (attr_r.access == acc_wo) ||
                     (attr_r.access == acc_rw);
  assign read_ok   = (attr_r.access == acc_ro) ||
                     (attr_r.access == acc_rw);

  // data register write carries the source in its upper half
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      param_data_r  <= 16'h0000;
      src_service_r <= 1'b0;
    end else if (data_wr && write_ok) begin
      // bus and service writes share one slot, so the latest write wins
      param_data_r  <= req.writedata[15:0];
      src_service_r <= src_service;
    end
  end

  // reboot-required values wait in a pending slot until a reboot strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      applied_r    <= 32'h0000_0000;
      pend_data_r  <= 16'h0000;
      pend_valid_r <= 1'b0;
    end else if (data_wr && write_ok) begin
      if (attr_r.reboot_req) begin
        pend_data_r  <= req.writedata[15:0];
        pend_valid_r <= 1'b1;
      end else begin
        applied_r <= decode_val(req.writedata[15:0],
                                attr_r.signed_value_flag);
      end
    end else if (reboot_wr && pend_valid_r) begin
      applied_r    <= decode_val(pend_data_r,
                                 attr_r.signed_value_flag);
      pend_valid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // step conversion from full steps to the selected drive mode

  drive_mode_t drive_mode_select;
  logic [15:0] steps_out;
  logic [7:0]  micro_div;

  assign drive_mode_select = drive_mode_t'(ctrl_r[ctrl_mode_lsb +: 2]);
  assign micro_div = ctrl_r[ctrl_micro_lsb +: 8];

  // micro-step factor comes from the ctrl register, so it is software programmable
  always_comb begin
    unique case (drive_mode_select)
      mode_full:  steps_out = steps_in_r;
      mode_half:  steps_out = {steps_in_r[14:0], 1'b0};
      mode_micro: steps_out = 16'((steps_in_r * micro_div));
      default:    steps_out = steps_in_r;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // millisecond tick and phase-aligned blink patterns

  localparam logic [16:0] tick_last = 17'(tick_cycles - 1);
  localparam logic [9:0]  ms_last   = 10'(period_ms - 1);
  logic [16:0] tick_cnt_r;
  logic [9:0]  ms_cnt_r;
  logic        tick;

  assign tick = (tick_cnt_r == tick_last);

  // single tick source keeps every pattern aligned
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 17'h0_0000;
    end else begin
      tick_cnt_r <= tick ? 17'h0_0000 : tick_cnt_r + 17'h0_0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_r <= 10'h000;
    end else if (tick) begin
      ms_cnt_r <= (ms_cnt_r == ms_last) ? 10'h000
                                        : ms_cnt_r + 10'h001;
    end
  end

  // on halves: slow 500, mid 250, fast 125 ms, all from one counter
  wire blink_slow = (ms_cnt_r < 10'(slow_half_ms));
  wire blink_mid  = ((ms_cnt_r % 10'(2*mid_half_ms)) <
                     10'(mid_half_ms));
  wire blink_fast = ((ms_cnt_r % 10'(2*fast_half_ms)) <
                     10'(fast_half_ms));

  ////////////////////////////////////////////////////////////////////////////
  // led drivers

  logic [num_valves-1:0] alarm_v;
  logic [num_valves-1:0] green_nxt;

  generate
    for (genvar v = 0; v < num_valves; v++) begin : g_valve
      wire [7:0] st = valve_r[v*8 +: 8];
      assign alarm_v[v] = st[valve_alarm_bit];
      // closed beats comm; mid marks comm so the two stay distinguishable
      always_comb begin
        if (!st[valve_power_bit]) begin
          green_nxt[v] = 1'b0;
        end else if (st[valve_closed_bit]) begin
          green_nxt[v] = blink_slow;
        end else if (st[valve_comm_bit]) begin
          green_nxt[v] = blink_mid;
        end else begin
          green_nxt[v] = st[valve_ready_bit];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      led <= '0;
    end else begin
      led.alarm <= (|alarm_v) ? blink_slow : 1'b0;
      led.valve <= green_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status cleared by read, set wins over clear

  logic [irq_bits-1:0] irq_stat_r;
  logic [irq_bits-1:0] irq_mask_r;
  logic [irq_bits-1:0] irq_set;
  logic                alarm_d_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_d_r <= 1'b0;
    end else begin
      alarm_d_r <= |alarm_v;
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[irq_applied_bit] = data_wr && write_ok && !attr_r.reboot_req;
    irq_set[irq_pending_bit] = data_wr && write_ok && attr_r.reboot_req;
    irq_set[irq_denied_bit]  = (data_wr && !write_ok) ||
                               (rd_any && req.address == param_val_off &&
                                !read_ok);
    irq_set[irq_alarm_bit]   = (|alarm_v) && !alarm_d_r;
  end

  wire stat_rd = rd_any && (req.address == irq_stat_off);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (stat_rd ? '0 : irq_stat_r) | irq_set;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_r <= irq_mask_rst;
    end else if (wr_any && req.address == irq_mask_off) begin
      irq_mask_r <= req.writedata[irq_bits-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((((stat_rd ? '0 : irq_stat_r) | irq_set)) & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    rerr_nxt  = 1'b0;
    unique case (req.address)
      ctrl_off:       rdata_nxt = ctrl_r;
      valve_off:      rdata_nxt = valve_r;
      param_addr_off: rdata_nxt = {16'h0000, param_addr_r};
      param_data_off: rdata_nxt = {15'h0000, src_service_r, param_data_r};
      param_attr_off: rdata_nxt = {16'h0000, attr_r.width_bits, 4'h0,
                                   attr_r.access, attr_r.reboot_req,
                                   attr_r.signed_value_flag};
      param_val_off: begin
        if (read_ok) begin
          rdata_nxt = applied_r;
        end else begin
          rerr_nxt = 1'b1;
        end
      end
      steps_in_off:   rdata_nxt = {16'h0000, steps_in_r};
      steps_out_off:  rdata_nxt = {16'h0000, steps_out};
      irq_stat_off:   rdata_nxt = {28'h000_0000, irq_stat_r};
      irq_mask_off:   rdata_nxt = {28'h000_0000, irq_mask_r};
      status_off:     rdata_nxt = {30'h0, pend_valid_r, |alarm_v};
      reboot_off:     rdata_nxt = 32'h0000_0000;
      default:        rerr_nxt  = 1'b1;
    endcase
  end

  // read data registered at the taking edge, so it stands only in the
  // answer cycle; the edge that closes the access must not load it again
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata     <= 32'h0000_0000;
      avs_response_err <= 1'b0;
    end else begin
      avs_readdata     <= (req.read && !busy_r) ? rdata_nxt : 32'h0000_0000;
      avs_response_err <= (req.read || req.write) && !busy_r && rerr_nxt;
    end
  end

endmodule

// ---- verification/valve_status_assertions.sv ----
// checker: port-level properties of the valve status block
`timescale 1ns/1ps

module valve_status_checker (
  input wire logic                   core_clk,
  input wire logic                   rst_n,
  input wire logic [5:0]             avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [3:0]             avs_byteenable,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  input wire logic                   avs_response_err,
  input wire valve_status_pkg::led_t led,
  input wire logic                   irq
);
  import valve_status_pkg::*;

  // every blink edge falls on a multiple of the fast half period
  localparam int grid = fast_half_ms * tick_cycles;

  logic wr_ok;
  int   cyc_r;

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  assign wr_ok = avs_write && !avs_waitrequest;

  // cycles since reset; the ms tick starts with it, so edges line up
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_r <= 0;
    end else begin
      cyc_r <= cyc_r + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_ack_single: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_ack_bound: assert property (
    (avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
    else $error("request not answered in time");
  a_ack_cause: assert property (
    !avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  a_err_with_ack: assert property (
    avs_response_err |-> !avs_waitrequest)
    else $error("error flag outside an answer");
  a_err_data_zero: assert property (
    avs_response_err && avs_read |-> avs_readdata == 32'h0)
    else $error("refused read returned data");
  a_mask_quiet_irq: assert property (
    wr_ok && avs_address == irq_mask_off && avs_writedata[3:0] == 4'h0
    |-> ##[1:3] !irq)
    else $error("irq stays high with all sources masked");
  a_alarm_dark_led: assert property (
    wr_ok && avs_address == valve_off && avs_byteenable == 4'hf
    && !avs_writedata[valve_alarm_bit] && !avs_writedata[8 + valve_alarm_bit]
    |-> ##[1:3] !led.alarm)
    else $error("alarm led lit without any alarm");
  a_power_dark_led: assert property (
    wr_ok && avs_address == valve_off && avs_byteenable[0]
    && !avs_writedata[valve_power_bit] |-> ##[1:3] !led.valve[0])
    else $error("green led lit without supply");
  a_led_tick_grid: assert property (
    $changed(led) |-> $past(wr_ok, 1) || $past(wr_ok, 2)
    || $past(wr_ok, 3) || (cyc_r % grid) < 4)
    else $error("led changed off the blink grid");

  cover property (avs_response_err && avs_read);
  cover property ($rose(irq));
  cover property ($rose(led.alarm));
endmodule

bind valve_status valve_status_checker i_valve_status_checker (
  .core_clk         (core_clk),
  .rst_n            (rst_n),
  .avs_address      (avs_address),
  .avs_read         (avs_read),
  .avs_write        (avs_write),
  .avs_writedata    (avs_writedata),
  .avs_byteenable   (avs_byteenable),
  .avs_readdata     (avs_readdata),
  .avs_waitrequest  (avs_waitrequest),
  .avs_response_err (avs_response_err),
  .led              (led),
  .irq              (irq)
);

// ---- verification/ctrl_model.sv ----
// partner model: upstream controller acting as bus master
`timescale 1ns/1ps

module ctrl_model (
  input  wire logic        core_clk,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_response_err,
  output logic [5:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable
);
  int hangs = 0;

  // idle bus at time zero; all lanes always enabled
  initial begin
    avs_address = 6'h3f;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
  end

  // hold the request until waitrequest is sampled low at an edge
  task automatic wait_ack();
    int n;
    for (n = 0; n < 64; n++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 64) begin
      hangs++;
      $display("Error %0t: bus request not answered", $time);
    end
  endtask

  // released lines show the inverse, so a stale value never looks valid
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    wait_ack();
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d,
                    output logic e);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    wait_ack();
    d = avs_readdata;
    e = avs_response_err;
    avs_read <= 1'b0;
    avs_address <= ~a;
  endtask
endmodule

// ---- verification/tb_top.sv ----
// testbench: register-level scenarios for the valve status block
`timescale 1ns/1ps

module tb_top;
  import valve_status_pkg::*;

  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        avs_response_err;
  led_t        led;
  logic        irq;
  int          bad_count  = 0;
  int          n_compared = 0;
  logic [31:0] rdata;
  logic        rerr;
  logic [31:0] raw_v [4] = '{32'h0, 32'h7fff, 32'h8000, 32'hffff};
  logic [31:0] sgn_v [4] = '{32'h0, 32'h7fff, 32'hffff_8000, 32'hffff_ffff};
  logic [31:0] stp_v [3] = '{32'd250, 32'd500, 32'd2000};

  always #5 core_clk = ~core_clk;

  valve_status i_valve_status (
    .core_clk         (core_clk),
    .rst_n            (rst_n),
    .avs_address      (avs_address),
    .avs_read         (avs_read),
    .avs_write        (avs_write),
    .avs_writedata    (avs_writedata),
    .avs_byteenable   (avs_byteenable),
    .avs_readdata     (avs_readdata),
    .avs_waitrequest  (avs_waitrequest),
    .avs_response_err (avs_response_err),
    .led              (led),
    .irq              (irq)
  );

  ctrl_model i_ctrl_model (
    .core_clk         (core_clk),
    .avs_waitrequest  (avs_waitrequest),
    .avs_readdata     (avs_readdata),
    .avs_response_err (avs_response_err),
    .avs_address      (avs_address),
    .avs_read         (avs_read),
    .avs_write        (avs_write),
    .avs_writedata    (avs_writedata),
    .avs_byteenable   (avs_byteenable)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    i_ctrl_model.rd(a, rdata, rerr);
    chk32(rdata, exp);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    i_ctrl_model.wr(a, d);
  endtask

  // led and irq are registered behind the register write
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic final_report();
    bad_count = bad_count + i_ctrl_model.hangs;
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk32({29'h0, led}, 32'h0);
    chk1(irq, 1'b0);
    rdc(ctrl_off, ctrl_rst);
    rdc(irq_mask_off, 32'h0);
    rdc(valve_off, valve_rst);
    // same raw values decoded signed, then unsigned
    wr(param_addr_off, 32'h0000_0102);
    for (int i = 0; i < 4; i++) begin
      wr(param_attr_off, 32'h0000_1009);
      wr(param_data_off, raw_v[i]);
      rdc(param_val_off, sgn_v[i]);
      wr(param_attr_off, 32'h0000_1008);
      wr(param_data_off, raw_v[i]);
      rdc(param_val_off, raw_v[i]);
    end
    // a reboot-bound value waits for the restart command
    wr(param_attr_off, 32'h0000_100a);
    wr(param_data_off, 32'h0000_0007);
    rdc(param_val_off, 32'h0000_ffff);
    rdc(status_off, 32'h0000_0002);
    wr(reboot_off, 32'h0000_0001);
    rdc(param_val_off, 32'h0000_0007);
    rdc(status_off, 32'h0000_0000);
    // service port write, then the controller overrides it
    wr(param_attr_off, 32'h0000_1008);
    wr(param_data_off, 32'h0001_0011);
    rdc(param_val_off, 32'h0000_0011);
    rdc(param_data_off, 32'h0001_0011);
    wr(param_data_off, 32'h0000_0022);
    rdc(param_val_off, 32'h0000_0022);
    rdc(param_data_off, 32'h0000_0022);
    // refused accesses raise the masked interrupt; a status read clears it
    wr(param_attr_off, 32'h0000_1000);
    wr(irq_mask_off, 32'h0000_0004);
    i_ctrl_model.rd(irq_stat_off, rdata, rerr);
    wr(param_data_off, 32'h0000_0033);
    settle();
    chk1(irq, 1'b1);
    rdc(param_val_off, 32'h0000_0022);
    rdc(irq_stat_off, 32'h0000_0004);
    settle();
    chk1(irq, 1'b0);
    wr(param_attr_off, 32'h0000_1004);
    i_ctrl_model.rd(param_val_off, rdata, rerr);
    chk32(rdata, 32'h0);
    chk1(rerr, 1'b1);
    i_ctrl_model.rd(irq_stat_off, rdata, rerr);
    chk1(rdata[irq_denied_bit], 1'b1);
    i_ctrl_model.rd(6'h30, rdata, rerr);
    chk32(rdata, 32'h0);
    chk1(rerr, 1'b1);
    // step values given in full steps, scaled by the drive mode
    wr(steps_in_off, 32'd250);
    for (int m = 0; m < 3; m++) begin
      wr(ctrl_off, 32'h0000_0800 | 32'(m));
      rdc(steps_out_off, stp_v[m]);
    end
    wr(ctrl_off, 32'h0000_0402);
    rdc(steps_out_off, 32'd1000);
    // leds start in the on half, so every blink shows lit here
    wr(irq_mask_off, 32'h0000_0008);
    wr(valve_off, 32'h0000_0003);
    settle();
    chk32({29'h0, led}, 32'h1);
    wr(valve_off, 32'h0000_1905);
    settle();
    chk32({29'h0, led}, 32'h7);
    chk1(irq, 1'b1);
    wr(valve_off, 32'h0000_0900);
    settle();
    chk32({29'h0, led}, 32'h2);
    wr(irq_mask_off, 32'h0);
    settle();
    chk1(irq, 1'b0);
    final_report();
  end

  // cut a hang short
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    $display("Error %0t: run did not finish", $time);
    final_report();
  end
endmodule
